// ---- src/fcd_dma.sv ----
`timescale 1ns/10ps
// Functional notes
// - Halfword 16-bit source to 8-bit destination: one read, two writes.
// - Halfword 8-bit source to 16-bit destination: two reads, one write.
// - Split bytes go low first in little endian, high first big endian.
// - Byte transfer is one read, one write; upper lanes undriven on 16-bit.
// - External bus cycles only for external targets.
// - Fixed priority, channel 0 highest, channel 3 lowest.
// - Block mode keeps its channel until the block ends or an NMI is pending.
// - Single-step yields to higher priority requests between units.
// - Address and count are master/slave pairs; engine uses slave.
// - Terminal count reloads slave from master.
// - Writes hit both stages when the channel is not running.
// - While running writes hit master only, reads return slave.
// - Software start needs trigger 1, enable 1, terminal flag 0.
// - Peripheral start needs request, enable 1, terminal flag 0.
// - NMI clears all enables after current unit and acknowledges NMI on the same clock.
// - Transfer end sets terminal flag and pulses end interrupt.
// - Reading the terminal flag clears it.
// - Two idle clocks between read and write cycles.
// - Halfword transfers force address bit 0 to zero; split byte cycles set it to the byte being moved.
module fcd_dma import fcd_pkg::*; (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               arst_n,
    // Setting writes and reads
    input  wire logic               set_wr,
    input  wire logic [1:0]         set_sel,
    input  wire logic [1:0]         set_ch,
    input  wire logic [AW-1:0]      set_wdata,
    input  wire logic [1:0]         rd_ch,
    output logic      [AW-1:0]      rd_src_addr,
    output logic      [AW-1:0]      rd_dst_addr,
    output logic      [CW-1:0]      rd_count,
    // Channel control
    input  wire logic [NCH-1:0]     sw_trigger,
    input  wire logic [NCH-1:0]     chan_enable,
    input  wire logic [NCH-1:0]     enable_set,
    input  wire logic [NCH-1:0]     force_terminate,
    input  wire logic [NCH-1:0]     periph_req,
    input  wire logic [NCH*2-1:0]   chan_mode,
    input  wire logic [NCH-1:0]     chan_half,
    input  wire logic [NCH*2-1:0]   src_tgt,
    input  wire logic [NCH*2-1:0]   dst_tgt,
    input  wire logic [NCH-1:0]     src_wide,
    input  wire logic [NCH-1:0]     dst_wide,
    input  wire logic               big_endian,
    input  wire logic [NCH-1:0]     tc_rd,
    input  wire logic               nmi,
    output logic      [NCH-1:0]     enable_st,
    output logic      [NCH-1:0]     term_count_flag,
    output logic      [NCH-1:0]     xfer_end_irq,
    output logic                    nmi_ack,
    // Target bus
    output logic                    bus_req,
    output logic                    bus_wr,
    output logic      [AW-1:0]      bus_addr,
    output logic      [1:0]         bus_tgt,
    output logic                    bus_ext,
    output logic      [1:0]         bus_be,
    output logic      [15:0]        bus_wdata,
    output logic                    bus_hi_oe_n,
    input  wire logic [15:0]        bus_rdata,
    input  wire logic               bus_done
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [NCH-1:0][AW-1:0] sa_m, sa_s, da_m, da_s;
        logic [NCH-1:0][CW-1:0] cnt_m, cnt_s;
        logic [NCH-1:0]         en, tc, irq, pend, run;
        fcd_state_t             st;
        logic [1:0]             ch;
        logic                   part;
        logic [15:0]            data;
        logic                   nmi_pend, nmi_ack;
        logic                   req, wr, ext, hi_oe_n;
        logic [AW-1:0]          addr;
        logic [1:0]             tgt, be;
        logic [15:0]            wdata;
        logic [AW-1:0]          rsa, rda;
        logic [CW-1:0]          rcnt;
    } fcd_regs_t;

    fcd_regs_t r, n;

    // Highest-priority pending channel
    function automatic logic [2:0] pick(input logic [NCH-1:0] v);
        pick = 3'h4;
        for (int i = NCH - 1; i >= 0; i--) begin
            if (v[i]) begin
                pick = {1'b0, 2'(i)};
            end
        end
    endfunction

    logic [1:0] c;
    logic [2:0] win;
    logic [1:0] md;
    logic       hw, sw_, dw, unit_done, last;

    always_comb begin
        n = r;
        c = r.ch;
        md = chan_mode[c*2 +: 2];
        hw = chan_half[c];
        sw_ = src_wide[c];
        dw = dst_wide[c];
        unit_done = 1'b0;
        last = 1'b0;
        n.irq = '0;
        n.nmi_ack = 1'b0;
        if (nmi) begin
            n.nmi_pend = 1'b1;
        end
        for (int i = 0; i < NCH; i++) begin
            if (enable_set[i]) begin
                n.en[i] = 1'b1;
            end
            if (tc_rd[i]) begin
                n.tc[i] = 1'b0;
            end
            if (chan_enable[i] && !r.tc[i] && r.en[i] && (sw_trigger[i] || periph_req[i])) begin
                n.pend[i] = 1'b1;
            end
            if (set_wr && set_ch == 2'(i)) begin
                if (set_sel == SEL_SA) n.sa_m[i] = set_wdata;
                if (set_sel == SEL_DA) n.da_m[i] = set_wdata;
                if (set_sel == SEL_CNT) n.cnt_m[i] = set_wdata[CW-1:0];
                if (!r.run[i]) begin
                    if (set_sel == SEL_SA) n.sa_s[i] = set_wdata;
                    if (set_sel == SEL_DA) n.da_s[i] = set_wdata;
                    if (set_sel == SEL_CNT) n.cnt_s[i] = set_wdata[CW-1:0];
                end
            end
            if (force_terminate[i] && !(r.st != ST_IDLE && r.ch == 2'(i))) begin
                n.pend[i] = 1'b0;
                n.run[i] = 1'b0;
                n.sa_s[i] = n.sa_m[i];
                n.da_s[i] = n.da_m[i];
                n.cnt_s[i] = n.cnt_m[i];
            end
        end
        win = pick(r.pend & r.en);
        case (r.st)
            ST_IDLE: begin
                if (r.nmi_pend) begin
                    n.en = '0;
                    n.pend = '0;
                    n.nmi_pend = nmi;
                    n.nmi_ack = 1'b1;
                end else if (!win[2]) begin
                    n.ch = win[1:0];
                    n.run[win[1:0]] = 1'b1;
                    n.part = 1'b0;
                    n.st = ST_READ;
                end
            end
            ST_READ: begin
                n.req = 1'b1;
                n.wr = 1'b0;
                n.tgt = src_tgt[c*2 +: 2];
                n.ext = (src_tgt[c*2 +: 2] == TGT_EXT);
                n.addr = hw ? {r.sa_s[c][AW-1:1], 1'b0} : r.sa_s[c];
                if (hw && !sw_) begin
                    n.addr[0] = r.part ^ big_endian;
                    n.be = 2'h1;
                end else begin
                    n.be = (hw) ? 2'h3 : 2'h1;
                end
                n.hi_oe_n = 1'b1;
                n.st = ST_WAITR;
            end
            ST_WAITR: begin
                if (bus_done) begin
                    n.req = 1'b0;
                    n.ext = 1'b0;
                    if (hw && !sw_) begin
                        if (r.part ^ big_endian) n.data[15:8] = bus_rdata[7:0];
                        else n.data[7:0] = bus_rdata[7:0];
                        n.part = ~r.part;
                        n.st = r.part ? ST_GAP : ST_READ;
                    end else begin
                        n.data = bus_rdata;
                        n.part = 1'b0;
                        n.st = ST_GAP;
                    end
                end
            end
            ST_GAP: begin
                n.st = ST_WRITE;
            end
            ST_WRITE: begin
                n.req = 1'b1;
                n.wr = 1'b1;
                n.tgt = dst_tgt[c*2 +: 2];
                n.ext = (dst_tgt[c*2 +: 2] == TGT_EXT);
                n.addr = hw ? {r.da_s[c][AW-1:1], 1'b0} : r.da_s[c];
                if (hw && !dw) begin
                    n.addr[0] = r.part ^ big_endian;
                    n.wdata = {8'h00, (r.part ^ big_endian) ? r.data[15:8] : r.data[7:0]};
                    n.be = 2'h1;
                    n.hi_oe_n = 1'b1;
                end else begin
                    n.wdata = r.data;
                    n.be = hw ? 2'h3 : 2'h1;
                    n.hi_oe_n = !(hw && dw);
                end
                n.st = ST_WAITW;
            end
            ST_WAITW: begin
                if (bus_done) begin
                    n.req = 1'b0;
                    n.ext = 1'b0;
                    n.hi_oe_n = 1'b1;
                    if (hw && !dw && !r.part) begin
                        n.part = 1'b1;
                        n.st = ST_WRITE;
                    end else begin
                        unit_done = 1'b1;
                    end
                end
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase
        if (unit_done) begin
            last = (r.cnt_s[c] == CNT_RST);
            n.sa_s[c] = r.sa_s[c] + (hw ? 28'h0000002 : 28'h0000001);
            n.da_s[c] = r.da_s[c] + (hw ? 28'h0000002 : 28'h0000001);
            n.cnt_s[c] = r.cnt_s[c] - 16'h0001;
            if (md == MODE_SINGLE) n.pend[c] = 1'b0;
            n.st = (md == MODE_BLOCK && !last && !r.nmi_pend) ? ST_READ : ST_IDLE;
            if (last) begin
                n.sa_s[c] = n.sa_m[c];
                n.da_s[c] = n.da_m[c];
                n.cnt_s[c] = n.cnt_m[c];
                n.run[c] = 1'b0;
                n.pend[c] = 1'b0;
                n.tc[c] = 1'b1;
                n.irq[c] = 1'b1;
            end
        end
        n.rsa = n.sa_s[rd_ch];
        n.rda = n.da_s[rd_ch];
        n.rcnt = n.cnt_s[rd_ch];
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
            r.st <= ST_IDLE;
            r.hi_oe_n <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign rd_src_addr     = r.rsa;
    assign rd_dst_addr     = r.rda;
    assign rd_count        = r.rcnt;
    assign enable_st       = r.en;
    assign term_count_flag = r.tc;
    assign xfer_end_irq    = r.irq;
    assign nmi_ack         = r.nmi_ack;
    assign bus_req         = r.req;
    assign bus_wr          = r.wr;
    assign bus_addr        = r.addr;
    assign bus_tgt         = r.tgt;
    assign bus_ext         = r.ext;
    assign bus_be          = r.be;
    assign bus_wdata       = r.wdata;
    assign bus_hi_oe_n     = r.hi_oe_n;

endmodule

// ---- src/fcd_pkg.sv ----
package fcd_pkg;

    // ****************************************
    // Sizes and encodings
    // ****************************************
    localparam int          NCH          = 4;
    localparam int          AW           = 28;
    localparam int          CW           = 16;
    localparam logic [1:0]  MODE_SINGLE  = 2'h0;
    localparam logic [1:0]  MODE_STEP    = 2'h1;
    localparam logic [1:0]  MODE_BLOCK   = 2'h2;
    localparam logic [1:0]  TGT_IRAM     = 2'h0;
    localparam logic [1:0]  TGT_PERI     = 2'h1;
    localparam logic [1:0]  TGT_EXT      = 2'h2;
    localparam logic [1:0]  SEL_SA       = 2'h0;
    localparam logic [1:0]  SEL_DA       = 2'h1;
    localparam logic [1:0]  SEL_CNT      = 2'h2;
    localparam int          GAP_CYCLES   = 1;
    localparam logic [AW-1:0] ADDR_RST   = 28'h0000000;
    localparam logic [CW-1:0] CNT_RST    = 16'h0000;

    // ****************************************
    // Engine states
    // ****************************************
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_READ  = 6'b000010,
        ST_WAITR = 6'b000100,
        ST_GAP   = 6'b001000,
        ST_WRITE = 6'b010000,
        ST_WAITW = 6'b100000
    } fcd_state_t;

endpackage

// ---- test/fcd_dma_assertions.sv ----
`timescale 1ns/10ps
// ****
// Engine bus and status checks
// ****
module fcd_dma_chk import fcd_pkg::*; (
    // Clock and reset
    input wire logic            sys_clk,
    input wire logic            arst_n,
    // Status
    input wire logic [NCH-1:0]  tc_rd,
    input wire logic [NCH-1:0]  enable_st,
    input wire logic [NCH-1:0]  term_count_flag,
    input wire logic [NCH-1:0]  xfer_end_irq,
    input wire logic            nmi_ack,
    // Target bus
    input wire logic            bus_req,
    input wire logic            bus_wr,
    input wire logic [AW-1:0]   bus_addr,
    input wire logic [1:0]      bus_tgt,
    input wire logic            bus_ext,
    input wire logic [1:0]      bus_be,
    input wire logic            bus_hi_oe_n,
    input wire logic            bus_done
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    ext_cycle_a: assert property (bus_req |-> bus_ext == (bus_tgt == TGT_EXT))
        else $error("external flag wrong");
    req_hold_a: assert property (bus_req && !bus_done |=> bus_req && $stable(bus_addr) && $stable(bus_wr))
        else $error("request dropped early");
    rd_gap_a: assert property (bus_req && !bus_wr && bus_done |=> !(bus_req && bus_wr) [*2])
        else $error("no idle clock before write");
    half_align_a: assert property (bus_req && bus_be == 2'h3 |-> !bus_addr[0])
        else $error("odd halfword address");
    irq_flag_a: assert property (xfer_end_irq != 4'h0 |=>
        (term_count_flag & $past(xfer_end_irq)) == $past(xfer_end_irq))
        else $error("end without flag");
    irq_pulse_a: assert property (xfer_end_irq != 4'h0 |=> (xfer_end_irq & $past(xfer_end_irq)) == 4'h0)
        else $error("end pulse too long");
    flag_clear_a: assert property (tc_rd != 4'h0 |=>
        (term_count_flag & $past(tc_rd) & ~xfer_end_irq) == 4'h0)
        else $error("flag not cleared by read");
    nmi_stop_a: assert property (nmi_ack |-> enable_st == 4'h0 && !bus_req)
        else $error("enables left on at suspend");
    hi_lane_a: assert property (bus_req && (!bus_wr || bus_be != 2'h3) |-> bus_hi_oe_n)
        else $error("upper lanes driven on byte cycle");
endmodule

// ---- test/fcd_mem_model.sv ----
`timescale 1ns/10ps
// ****
// Memory and peripheral side
// ****
module fcd_mem_model import fcd_pkg::*; (
    // Clock
    input  wire logic           sys_clk,
    // Bus from the engine
    input  wire logic           bus_req,
    input  wire logic           bus_wr,
    input  wire logic [AW-1:0]  bus_addr,
    input  wire logic           bus_ext,
    input  wire logic [15:0]    bus_wdata,
    input  wire logic [7:0]     dly,
    output logic      [15:0]    bus_rdata,
    output logic                bus_done
);
    logic [AW-1:0]  ra[$];
    logic [15:0]    wd[$];
    int             n_ext;
    int             cnt;
    initial begin
        bus_done = 1'h0;
        bus_rdata = 16'h0000;
        n_ext = 0;
        cnt = 0;
    end
    always @(posedge sys_clk) begin
        bus_done <= 1'h0;
        // Data lines toggle when not answering
        bus_rdata <= ~bus_rdata;
        if (bus_req && !bus_done) begin
            if (cnt >= dly) begin
                cnt <= 0;
                bus_done <= 1'h1;
                bus_rdata <= 16'hA55A;
                n_ext <= n_ext + int'(bus_ext);
                if (bus_wr)
                    wd.push_back(bus_wdata);
                else
                    ra.push_back(bus_addr);
            end else begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule

// ---- test/four_channel_dma_control_tb.sv ----
`timescale 1ns/10ps
module four_channel_dma_control_tb import fcd_pkg::*; ;
    logic            sys_clk, arst_n, set_wr, big_endian, nmi, nmi_ack, bus_req, bus_wr, bus_ext, bus_hi_oe_n, bus_done;
    logic [1:0]      set_sel, set_ch, rd_ch, bus_tgt, bus_be;
    logic [AW-1:0]   set_wdata, rd_src_addr, rd_dst_addr, bus_addr;
    logic [CW-1:0]   rd_count;
    logic [NCH-1:0]  sw_trigger, chan_enable, enable_set, force_terminate, periph_req, chan_half;
    logic [NCH-1:0]  src_wide, dst_wide, tc_rd, enable_st, term_count_flag, xfer_end_irq;
    logic [7:0]      chan_mode, src_tgt, dst_tgt, dly;
    logic [15:0]     bus_wdata, bus_rdata;
    int              miscompares, checked, r0, w0, e0;

    fcd_dma dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .set_wr(set_wr), .set_sel(set_sel), .set_ch(set_ch),
        .set_wdata(set_wdata), .rd_ch(rd_ch), .rd_src_addr(rd_src_addr), .rd_dst_addr(rd_dst_addr),
        .rd_count(rd_count), .sw_trigger(sw_trigger), .chan_enable(chan_enable), .enable_set(enable_set),
        .force_terminate(force_terminate), .periph_req(periph_req), .chan_mode(chan_mode),
        .chan_half(chan_half), .src_tgt(src_tgt), .dst_tgt(dst_tgt), .src_wide(src_wide),
        .dst_wide(dst_wide), .big_endian(big_endian), .tc_rd(tc_rd), .nmi(nmi), .enable_st(enable_st),
        .term_count_flag(term_count_flag), .xfer_end_irq(xfer_end_irq), .nmi_ack(nmi_ack), .bus_req(bus_req),
        .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_tgt(bus_tgt), .bus_ext(bus_ext), .bus_be(bus_be),
        .bus_wdata(bus_wdata), .bus_hi_oe_n(bus_hi_oe_n), .bus_rdata(bus_rdata), .bus_done(bus_done));
    fcd_mem_model m_u (.sys_clk(sys_clk), .bus_req(bus_req), .bus_wr(bus_wr), .bus_addr(bus_addr),
        .bus_ext(bus_ext), .bus_wdata(bus_wdata), .dly(dly), .bus_rdata(bus_rdata), .bus_done(bus_done));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic setw(input int ch, input int sel, input logic [AW-1:0] d);
        @(negedge sys_clk);
        set_wr = 1'h1;
        set_ch = ch[1:0];
        set_sel = sel[1:0];
        set_wdata = d;
        @(negedge sys_clk);
        set_wr = 1'h0;
    endtask
    task automatic prep(input int ch, input int cnt);
        setw(ch, 0, AW'(ch << 8));
        setw(ch, 1, AW'(28'h0000400 + ch));
        setw(ch, 2, AW'(cnt));
    endtask
    task automatic go(input logic [3:0] m);
        @(negedge sys_clk);
        enable_set = m;
        @(negedge sys_clk);
        enable_set = 4'h0;
        sw_trigger = m;
        @(negedge sys_clk);
        sw_trigger = 4'h0;
    endtask
    // Bounded wait on bus_done, nmi_ack or an end pulse
    task automatic wt(input int b);
        logic [5:0] v;
        for (int i = 0; i < 3000; i++) begin
            @(negedge sys_clk);
            v = {bus_done, nmi_ack, xfer_end_irq};
            if (v[b] === 1'h1)
                return;
        end
        miscompares++;
        end_of_test();
    endtask
    task automatic pulse_rd(input logic [3:0] m);
        @(negedge sys_clk);
        tc_rd = m;
        @(negedge sys_clk);
        tc_rd = 4'h0;
    endtask

    initial begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial begin
        {set_wr, nmi, big_endian, sw_trigger, enable_set, force_terminate, periph_req, tc_rd} = '0;
        {chan_half, src_wide, dst_wide, set_sel, set_ch, rd_ch, set_wdata, chan_mode, src_tgt, dly} = '0;
        chan_enable = 4'hF;
        dst_tgt = 8'hAA;
        arst_n = 1'h0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        arst_n = 1'h1;
        chk(enable_st, 4'h0);
        chk(term_count_flag, 4'h0);
        chk(bus_hi_oe_n, 1'h1);
        chk(bus_req, 1'h0);
        $display("reset test done");
        for (int k = 0; k < 4; k++) begin
            chan_half[0] = k != 2;
            src_wide[0] = k != 1;
            dst_wide[0] = k == 1;
            big_endian = k == 3;
            prep(0, 0);
            r0 = m_u.ra.size();
            w0 = m_u.wd.size();
            e0 = m_u.n_ext;
            go(4'h1);
            wt(0);
            chk(m_u.ra.size() - r0, (k == 1) ? 2 : 1);
            chk(m_u.wd.size() - w0, (k == 0 || k == 3) ? 2 : 1);
            chk(m_u.n_ext - e0, m_u.wd.size() - w0);
            if (k == 0 || k == 3)
                chk(m_u.wd[w0][7:0], (k == 3) ? 8'hA5 : 8'h5A);
            chk(term_count_flag[0], 1'h1);
            go(4'h1);
            repeat (20) @(negedge sys_clk);
            chk(m_u.ra.size() - r0, (k == 1) ? 2 : 1);
            pulse_rd(4'h1);
            chk(term_count_flag[0], 1'h0);
        end
        $display("size test done");
        {chan_half, src_wide, big_endian} = '0;
        chan_mode = {MODE_SINGLE, 2'h0, MODE_STEP, 2'h0};
        prep(1, 0);
        prep(3, 0);
        r0 = m_u.ra.size();
        go(4'hA);
        wt(3);
        chk(m_u.ra[r0], 28'h0000100);
        pulse_rd(4'hF);
        $display("priority test done");
        dly = 8'h03;
        rd_ch = 2'h2;
        chan_mode[5:4] = MODE_STEP;
        prep(2, 3);
        repeat (2) @(negedge sys_clk);
        chk(rd_count, 16'h0003);
        chk(rd_src_addr, 28'h0000200);
        chk(rd_dst_addr, 28'h0000402);
        go(4'h4);
        wt(5);
        setw(2, 2, 28'h0000005);
        repeat (2) @(negedge sys_clk);
        chk(rd_count, 16'h0003);
        wt(2);
        repeat (2) @(negedge sys_clk);
        chk(rd_count, 16'h0005);
        pulse_rd(4'h4);
        $display("reload test done");
        prep(3, 0);
        periph_req = 4'h8;
        @(negedge sys_clk);
        periph_req = 4'h0;
        wt(3);
        chk(term_count_flag[3], 1'h1);
        pulse_rd(4'h8);
        $display("peripheral start test done");
        chan_mode[1:0] = MODE_BLOCK;
        prep(0, 32);
        go(4'h1);
        wt(5);
        nmi = 1'h1;
        @(negedge sys_clk);
        nmi = 1'h0;
        wt(4);
        chk(enable_st, 4'h0);
        $display("suspend test done");
        end_of_test();
    end
endmodule

bind fcd_dma fcd_dma_chk chk_u (.sys_clk(sys_clk), .arst_n(arst_n), .tc_rd(tc_rd), .enable_st(enable_st),
    .term_count_flag(term_count_flag), .xfer_end_irq(xfer_end_irq), .nmi_ack(nmi_ack), .bus_req(bus_req),
    .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_tgt(bus_tgt), .bus_ext(bus_ext), .bus_be(bus_be),
    .bus_hi_oe_n(bus_hi_oe_n), .bus_done(bus_done));
